// ---- core/sebp_pkg.sv ----
// Purpose: Shared constants and types for the serial EEPROM bit-bang port.
// Assumes: 50 MHz clock, AXI4-Lite register access with 32-bit data.
// Notes:   Every offset, field position and timing count, and the store enable reset value, live here.
package sebp_pkg;
  // ****************************************
  // Register map
  // ****************************************
  // Register index of the serial port / readback register.
  localparam logic [9:0] REG_IDX = 10'h00A;
  // Byte address of that register: four times the index.
  localparam logic [11:0] REG_ADDR = {REG_IDX, 2'h0};
  // Bit that carries the serial data in both directions.
  localparam int BIT_DATA = 7;
  // Bit that requests a serial clock pulse and keeps the memory selected.
  localparam int BIT_SCLK = 0;
  // Reset value of the store enable latch: stores are locked.
  localparam logic STORE_EN_RST = 1'b0;
  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************
  // Serial command layout
  // ****************************************
  // Opcode plus address bits that follow the start bit.
  localparam logic [4:0] HDR_BITS = 5'h08;
  // Data bits of one stored word.
  localparam logic [4:0] DATA_BITS = 5'h10;
  // Opcodes.
  localparam logic [1:0] OPC_EXT = 2'h0;
  localparam logic [1:0] OPC_WRITE = 2'h1;
  localparam logic [1:0] OPC_READ = 2'h2;
  // Top two address bits that select enable or disable under the extended opcode.
  localparam logic [1:0] EXT_ENABLE = 2'h3;
  localparam logic [1:0] EXT_DISABLE = 2'h0;
  // Header bits that identify an extended command: opcode plus two address bits.
  localparam logic [4:0] EXT_BITS = 5'h04;
  // ****************************************
  // Timing
  // ****************************************
  // Busy time after a store, in milliseconds.
  localparam int BUSY_MS = 20;
  // Clock rate in hertz.
  localparam int CLK_HZ = 50000000;
  // Busy time in clock cycles.
  localparam int BUSY_CYC = BUSY_MS * (CLK_HZ / 1000);
  // ****************************************
  // Types
  // ****************************************
  // Sequencer states.
  typedef enum logic [2:0] {SE_IDLE, SE_HDR, SE_DATA, SE_LOAD, SE_RDOUT, SE_HOLD} sebp_state_t;
  // Layout of the readback byte.
  typedef struct packed {
    logic dat;
    logic [1:0] rsv;
    logic scan;
    logic [3:0] chan;
  } sebp_rb_t;
  // Write request toward the word store.
  typedef struct packed {
    logic we;
    logic [5:0] addr;
    logic [15:0] data;
  } sebp_wr_t;
endpackage : sebp_pkg

// ---- core/sebp_store.sv ----
// Purpose: Flip-flop word store behind the serial port.
// Assumes: One write port and one combinational read port.
// Notes:   Contents are undefined until written, as in a blank memory.
`timescale 1ns/1ps
module sebp_store #(
  parameter int AW = 6,
  parameter int DW = 16
) (
  input wire logic CLK,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  // Storage words, addressed by index.
  logic [DW-1:0] mem_r [2**AW];
  // Next value of the addressed word.
  logic [DW-1:0] word_nxt;

  // ****************************************
  // Write path
  // ****************************************
  // Computes the new content of the addressed word.
  always_comb begin
    word_nxt = mem_r[waddr];
    if (we) begin
      word_nxt = wdata;
    end
  end

  // Registers the addressed word.
  always_ff @(posedge CLK) begin
    mem_r[waddr] <= word_nxt;
  end

  // Read port.
  assign rdata = mem_r[raddr];
endmodule : sebp_store

// ---- core/sebp_port.sv ----
// Purpose: Register-driven serial port to a small word store, reached over AXI4-Lite.
// Assumes: Software writes one byte per serial bit and reads one bit per read.
// Notes:   Channel and scan flag inputs come from converter logic on the same clock.
`timescale 1ns/1ps
// Contract
// - Busy 20 ms after store; accesses ignored.
// - Stores ignored until enable sequence sent.
// - Disable sequence locks stores again.
// - Fetch reads return bits MSB first.
// - Bits 3..0 report current converter channel.
// - Scan flag low at end address.
module sebp_port #(
  parameter int ADDR_BITS = 6,
  parameter int BUSY_CYCLES = sebp_pkg::BUSY_CYC
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [3:0] CHANNEL_NUM,
  input wire logic SCAN_NOT_AT_END_FLAG,
  output logic SER_CS,
  output logic SERIAL_CLOCK_BIT,
  output logic SER_DI,
  output logic STORE_BUSY
);
  // ****************************************
  // Elaboration checks
  // ****************************************
  // The layout fixes six address bits; the busy counter holds 24 bits.
  if (ADDR_BITS != 6 || BUSY_CYCLES < 1 || BUSY_CYCLES > 16777215) begin : g_bad_param
    $error("ADDR_BITS must be 6 and BUSY_CYCLES from 1 to 16777215");
  end
  localparam logic [23:0] BUSY_LOAD = 24'(BUSY_CYCLES);
  // ****************************************
  // State
  // ****************************************
  // Bus side: captured address/data flags and answers.
  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [11:0] awaddr_r, awaddr_nxt;
  logic [7:0] wbyte_r, wbyte_nxt;
  logic wlane_r, wlane_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  // Serial side: sequencer, bit counter, shifters and enables.
  sebp_pkg::sebp_state_t st_r, st_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [7:0] hdr_r, hdr_nxt;
  logic [15:0] sh_r, sh_nxt;
  logic store_en_r, store_en_nxt;
  logic [23:0] busy_r, busy_nxt;
  logic cs_r, cs_nxt, sclk_r, sclk_nxt, di_r, di_nxt;
  // Write request toward the store and its read word.
  sebp_pkg::sebp_wr_t wr_nxt;
  logic [15:0] store_rdata;
  // Readback byte.
  sebp_pkg::sebp_rb_t rb;
  // Returns true when a byte address hits the port register.
  function automatic logic hit(input logic [11:0] a);
    hit = (a[11:2] == sebp_pkg::REG_IDX);
  endfunction : hit
  // ****************************************
  // Next-state logic
  // ****************************************
  // Computes bus answers and serial sequencing for one cycle.
  always_comb begin
    logic wr_ev, rd_ev, b;
    logic [7:0] hv;
    wr_ev = 1'b0;
    rd_ev = 1'b0;
    b = 1'b0;
    hv = 8'h00;
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    awaddr_nxt = awaddr_r;
    wbyte_nxt = wbyte_r;
    wlane_nxt = wlane_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    hdr_nxt = hdr_r;
    sh_nxt = sh_r;
    store_en_nxt = store_en_r;
    busy_nxt = (busy_r != 24'h000000) ? busy_r - 24'h000001 : busy_r;
    cs_nxt = cs_r;
    sclk_nxt = 1'b0;
    di_nxt = di_r;
    wr_nxt = '{we: 1'b0, addr: hdr_r[5:0], data: sh_r};
    // Address and data are taken independently, in either order.
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_got_nxt = 1'b1;
      wbyte_nxt = S_AXI_WDATA[7:0];
      wlane_nxt = S_AXI_WSTRB[0];
    end
    // With both halves held, the write completes and the response rises.
    if (aw_got_r && w_got_r) begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = hit(awaddr_r) ? sebp_pkg::RESP_OKAY : sebp_pkg::RESP_SLVERR;
      wr_ev = hit(awaddr_r) && wlane_r;
    end
    if (S_AXI_BVALID && S_AXI_BREADY) begin
      bvalid_nxt = 1'b0;
    end
    // A read is answered the cycle after it is taken.
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = hit(S_AXI_ARADDR) ? sebp_pkg::RESP_OKAY : sebp_pkg::RESP_SLVERR;
      rdata_nxt = hit(S_AXI_ARADDR) ? {24'h000000, rb} : 32'h00000000;
      rd_ev = hit(S_AXI_ARADDR);
    end
    if (S_AXI_RVALID && S_AXI_RREADY) begin
      rvalid_nxt = 1'b0;
    end
    // The read word is loaded once the header has named it.
    if (st_r == sebp_pkg::SE_LOAD) begin
      sh_nxt = store_rdata;
      st_nxt = sebp_pkg::SE_RDOUT;
    end
    // Each read of the port register during readout moves the next bit into bit 7.
    if (rd_ev && st_r == sebp_pkg::SE_RDOUT) begin
      sh_nxt = {sh_r[14:0], 1'b0};
    end
    if (wr_ev) begin
      b = wbyte_r[sebp_pkg::BIT_DATA];
      di_nxt = b;
      cs_nxt = wbyte_r[sebp_pkg::BIT_SCLK];
      sclk_nxt = wbyte_r[sebp_pkg::BIT_SCLK];
      hv = {hdr_r[6:0], b};
      if (!wbyte_r[sebp_pkg::BIT_SCLK]) begin
        // Deselect ends any transaction; a full store commits here.
        if (st_r == sebp_pkg::SE_DATA && cnt_r == sebp_pkg::DATA_BITS && store_en_r && busy_r == 24'h000000) begin
          wr_nxt.we = 1'b1;
          busy_nxt = BUSY_LOAD;
        end
        st_nxt = sebp_pkg::SE_IDLE;
      end else if (busy_r != 24'h000000) begin
        st_nxt = sebp_pkg::SE_IDLE;
      end else begin
        case (st_r)
          sebp_pkg::SE_IDLE: begin
            // Only a one on the data line counts as the start bit.
            if (b) begin
              st_nxt = sebp_pkg::SE_HDR;
              cnt_nxt = 5'h00;
              hdr_nxt = 8'h00;
            end
          end
          sebp_pkg::SE_HDR: begin
            hdr_nxt = hv;
            cnt_nxt = cnt_r + 5'h01;
            // The disable command arrives one bit short of a header, so it is decoded early.
            if (cnt_r == sebp_pkg::EXT_BITS - 5'h01 && hv[3:0] == {sebp_pkg::OPC_EXT, sebp_pkg::EXT_DISABLE}) begin
              store_en_nxt = 1'b0;
            end
            if (cnt_r == sebp_pkg::HDR_BITS - 5'h01) begin
              cnt_nxt = 5'h00;
              case (hv[7:6])
                sebp_pkg::OPC_WRITE: st_nxt = sebp_pkg::SE_DATA;
                sebp_pkg::OPC_READ: st_nxt = sebp_pkg::SE_LOAD;
                sebp_pkg::OPC_EXT: begin
                  if (hv[5:4] == sebp_pkg::EXT_ENABLE) begin
                    store_en_nxt = 1'b1;
                  end
                  st_nxt = sebp_pkg::SE_HOLD;
                end
                default: st_nxt = sebp_pkg::SE_HOLD;
              endcase
            end
          end
          sebp_pkg::SE_DATA: begin
            // Extra bits beyond the word are ignored.
            if (cnt_r != sebp_pkg::DATA_BITS) begin
              sh_nxt = {sh_r[14:0], b};
              cnt_nxt = cnt_r + 5'h01;
            end
          end
          default: st_nxt = st_r; // Clock pulses during readout or hold change nothing.
        endcase
      end
    end
  end
  // ****************************************
  // Registers
  // ****************************************
  // Registers every state element; synchronous active-low reset.
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 12'h000;
      wbyte_r <= 8'h00;
      wlane_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= sebp_pkg::RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= sebp_pkg::RESP_OKAY;
      rdata_r <= 32'h00000000;
      st_r <= sebp_pkg::SE_IDLE;
      cnt_r <= 5'h00;
      hdr_r <= 8'h00;
      sh_r <= 16'h0000;
      store_en_r <= sebp_pkg::STORE_EN_RST;
      busy_r <= 24'h000000;
      cs_r <= 1'b0;
      sclk_r <= 1'b0;
      di_r <= 1'b0;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wbyte_r <= wbyte_nxt;
      wlane_r <= wlane_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      hdr_r <= hdr_nxt;
      sh_r <= sh_nxt;
      store_en_r <= store_en_nxt;
      busy_r <= busy_nxt;
      cs_r <= cs_nxt;
      sclk_r <= sclk_nxt;
      di_r <= di_nxt;
    end
  end
  // ****************************************
  // Word store and outputs
  // ****************************************
  // Holds the stored words.
  sebp_store #(.AW(ADDR_BITS), .DW(16)) u_store (
    .CLK(CLK),
    .we(wr_nxt.we),
    .waddr(wr_nxt.addr),
    .wdata(wr_nxt.data),
    .raddr(hdr_r[5:0]),
    .rdata(store_rdata)
  );
  // Readback: data bit during readout, else ready; channel and scan flag.
  assign rb.dat = (st_r == sebp_pkg::SE_RDOUT) ? sh_r[15] : (busy_r == 24'h000000);
  assign rb.rsv = 2'h0;
  assign rb.scan = SCAN_NOT_AT_END_FLAG;
  assign rb.chan = CHANNEL_NUM;
  assign S_AXI_AWREADY = !aw_got_r && !bvalid_r;
  assign S_AXI_WREADY = !w_got_r && !bvalid_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_ARREADY = !rvalid_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RRESP = rresp_r;
  assign S_AXI_RDATA = rdata_r;
  assign SER_CS = cs_r;
  assign SERIAL_CLOCK_BIT = sclk_r;
  assign SER_DI = di_r;
  assign STORE_BUSY = busy_r != 24'h000000;
endmodule : sebp_port

// ---- tb/sebp_port_assertions.sv ----
// Purpose: Port-level assertions for the serial port block.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound to every instance of the port module.
`timescale 1ns/1ps
module sebp_port_assertions #(
  parameter int BUSY_CYCLES = 50
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_RVALID,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic [3:0] CHANNEL_NUM,
  input wire logic SCAN_NOT_AT_END_FLAG,
  input wire logic SER_CS,
  input wire logic SERIAL_CLOCK_BIT,
  input wire logic SER_DI,
  input wire logic STORE_BUSY
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  // Counts consecutive busy cycles.
  logic [31:0] busy_cnt_r;
  logic [31:0] busy_cnt_nxt;
  always_comb begin
    busy_cnt_nxt = STORE_BUSY ? busy_cnt_r + 32'h1 : 32'h0;
  end
  always_ff @(posedge CLK) begin
    busy_cnt_r <= NRST ? busy_cnt_nxt : 32'h0;
  end
  pulse_one_a: assert property (SERIAL_CLOCK_BIT |=> !SERIAL_CLOCK_BIT)
    else $error("Serial clock pulse too long");
  pulse_cause_a: assert property (SERIAL_CLOCK_BIT |-> $rose(S_AXI_BVALID) && SER_CS)
    else $error("Serial clock pulse without a selecting write");
  cs_change_a: assert property (!$stable(SER_CS) |-> $rose(S_AXI_BVALID))
    else $error("Select changed without a write");
  di_change_a: assert property (!$stable(SER_DI) |-> $rose(S_AXI_BVALID))
    else $error("Serial data changed without a write");
  busy_len_a: assert property ($fell(STORE_BUSY) |-> busy_cnt_r == BUSY_CYCLES)
    else $error("Busy time has the wrong length");
  busy_start_a: assert property ($rose(STORE_BUSY) |-> !SER_CS)
    else $error("Busy began while still selected");
  chan_show_a: assert property ($rose(S_AXI_RVALID) && S_AXI_RRESP == 2'h0 |->
    S_AXI_RDATA[3:0] == $past(CHANNEL_NUM)) else $error("Channel bits wrong");
  scan_show_a: assert property ($rose(S_AXI_RVALID) && S_AXI_RRESP == 2'h0 |->
    S_AXI_RDATA[4] == $past(SCAN_NOT_AT_END_FLAG)) else $error("Scan flag wrong");
  rd_upper_a: assert property ($rose(S_AXI_RVALID) |->
    S_AXI_RDATA[31:8] == 24'h0 && S_AXI_RDATA[6:5] == 2'h0) else $error("Unused bits set");
endmodule : sebp_port_assertions
bind sebp_port sebp_port_assertions #(.BUSY_CYCLES(BUSY_CYCLES)) sebp_port_assertions_inst (
  .CLK(CLK), .NRST(NRST), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .CHANNEL_NUM(CHANNEL_NUM),
  .SCAN_NOT_AT_END_FLAG(SCAN_NOT_AT_END_FLAG), .SER_CS(SER_CS),
  .SERIAL_CLOCK_BIT(SERIAL_CLOCK_BIT), .SER_DI(SER_DI), .STORE_BUSY(STORE_BUSY)
);

// ---- tb/tb.sv ----
// Purpose: Self-checking bench for the serial port block.
// Assumes: Short busy time; the bench is the bus master.
// Notes: A monitor compares each response with a queued note.
`timescale 1ns/1ps
module tb;
  localparam int BC = 50;
  localparam logic [11:0] A = sebp_pkg::REG_ADDR;
  logic clk = 1'h0, nrst = 1'h0, scan = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, cs, sck, di, busy;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  logic [3:0] chan = 4'h0;
  logic [33:0] rq[$];
  logic [3:0] bq[$];
  // Expected select and serial data levels after the latest write.
  logic [1:0] sel_e = 2'h0;
  logic [15:0] word;
  logic [5:0] ad;
  int n_fail = 0, n_compared = 0, seed = 82;
  sebp_port #(.BUSY_CYCLES(BC)) sebp_port_inst (.CLK(clk), .NRST(nrst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .CHANNEL_NUM(chan), .SCAN_NOT_AT_END_FLAG(scan), .SER_CS(cs), .SERIAL_CLOCK_BIT(sck),
    .SER_DI(di), .STORE_BUSY(busy));
  initial begin
    forever #10 clk = ~clk;
  end
  // Compares one result with its note.
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Takes the oldest note whenever a response is accepted.
  always @(posedge clk) begin
    if (rvalid === 1'h1 && rready === 1'h1) chk({rresp, rdata}, rq.pop_front());
    if (bvalid === 1'h1 && bready === 1'h1) chk({30'h0, cs, di, bresp}, {30'h0, bq.pop_front()});
  end
  // One bus write; address and data released as each is taken.
  task automatic wr(input logic [11:0] a, input logic [7:0] b, input logic [1:0] r = 2'h0);
    int t;
    // A mapped write moves select to bit 0 and serial data to bit 7; others leave them.
    if (r == 2'h0) sel_e = {b[0], b[7]};
    bq.push_back({sel_e, r});
    awaddr <= a;
    wdata <= {24'h0, b};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1 && t < 100);
    if (bvalid !== 1'h1) n_fail++;
    bready <= 1'h0;
    @(posedge clk);
  endtask : wr
  // One bus read with fresh random channel and scan inputs.
  task automatic rd(input logic [11:0] a, input logic b7, input logic [1:0] r = 2'h0);
    int t;
    logic [4:0] v;
    v = 5'($random(seed));
    chan <= v[3:0];
    scan <= v[4];
    rq.push_back(r != 2'h0 ? {r, 32'h0} : {r, 24'h0, b7, 2'h0, v});
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1 && t < 100);
    if (rvalid !== 1'h1) n_fail++;
    rready <= 1'h0;
    @(posedge clk);
  endtask : rd
  // Sends the low n bits of v, first bit the highest.
  task automatic send(input logic [24:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      wr(A, {v[i], 7'h01});
    end
  endtask : send
  // Full store; en says whether the store is expected to take.
  task automatic store(input logic [5:0] a, input logic [15:0] d, input logic en);
    int t;
    send({1'h1, 2'h1, a, d}, 25);
    wr(A, 8'h00);
    rd(A, !en);
    t = 0;
    while (busy !== 1'h0 && t < 1000) begin
      @(posedge clk);
      t++;
    end
    if (busy !== 1'h0) n_fail++;
  endtask : store
  // Full fetch, checking every bit as it is read.
  task automatic fetch(input logic [5:0] a, input logic [15:0] d);
    send({16'h0, 1'h1, 2'h2, a}, 9);
    repeat (2) @(posedge clk);
    for (int i = 15; i >= 0; i--) begin
      rd(A, d[i]);
    end
    wr(A, 8'h00);
  endtask : fetch
  task automatic results();
    // Notes that were never answered count as failures.
    n_fail += rq.size() + bq.size();
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  initial begin
    #400000;
    n_fail++;
    results();
  end
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    rd(A, 1'h1);
    rd(12'h02C, 1'h0, 2'h2);
    wr(12'h02C, 8'h81, 2'h2);
    store(6'h05, 16'hAA55, 1'h0);
    send(25'h130, 9);
    wr(A, 8'h00);
    for (int k = 0; k < 3; k++) begin
      ad = (k == 0) ? 6'h00 : (k == 1) ? 6'h3F : 6'($random(seed));
      word = 16'($random(seed));
      store(ad, word, 1'h1);
      fetch(ad, word);
    end
    send(25'h80, 8);
    wr(A, 8'h00);
    store(ad, ~word, 1'h0);
    fetch(ad, word);
    send(25'h130, 9);
    wr(A, 8'h00);
    store(ad, ~word, 1'h1);
    fetch(ad, ~word);
    repeat (3) @(posedge clk);
    results();
  end
endmodule : tb
